// ==== sac_pkg.sv ====
package sac_pkg;

  // ----------------------------------------------------------------
  // sizes and counts
  // ----------------------------------------------------------------
  localparam int SAC_N = 36;
  localparam int SAC_CODE_W = 8;
  localparam int SAC_IDX_W = 6;
  localparam int SAC_ENC_FAULT_RUN = 3;
  localparam int SAC_FREQ_W = 16;
  localparam int SAC_PERR_W = 24;
  localparam logic [SAC_CODE_W-1:0] SAC_CODE_NONE = 8'h00;

  // ----------------------------------------------------------------
  // entry positions used by the logic
  // ----------------------------------------------------------------
  localparam int SAC_IDX_OVERVOLT = 0;
  localparam int SAC_IDX_OVERCUR = 1;
  localparam int SAC_IDX_PULSE_FREQ = 6;
  localparam int SAC_IDX_POS_ERR = 7;
  localparam int SAC_IDX_ENC_COMM = 8;
  localparam int SAC_IDX_NVM = 11;
  localparam int SAC_IDX_ENC_REL = 16;
  localparam int SAC_IDX_MOTOR_HOT = 17;
  localparam int SAC_IDX_SER_CRC = 18;
  localparam int SAC_IDX_SER_TMO = 19;
  localparam int SAC_IDX_ENC_HOT = 24;
  localparam int SAC_IDX_REGEN = 25;
  localparam int SAC_IDX_UNDERVOLT = 27;
  localparam int SAC_IDX_ESTOP = 28;
  localparam int SAC_IDX_CCW = 29;
  localparam int SAC_IDX_CW = 30;
  localparam int SAC_IDX_PHASE = 32;
  localparam int SAC_IDX_FAN = 34;
  localparam int SAC_IDX_DSP = 35;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SAC_CODE_W-1:0] code;
    logic warn;
    logic keep_on;
  } sac_entry_t;

  typedef struct packed {
    logic valid;
    logic bad;
  } sac_enc_frame_t;

  typedef struct packed {
    logic [SAC_CODE_W-1:0] code;
    logic fault;
    logic warn;
    logic servo_off;
  } sac_ind_t;

  typedef struct packed {
    logic [SAC_N-1:0] latch;
    sac_ind_t ind;
  } sac_state_t;

  typedef struct packed {
    logic [1:0] run;
    logic fault;
  } sac_enc_state_t;

  localparam sac_state_t SAC_STATE_RST = '0;
  localparam sac_enc_state_t SAC_ENC_STATE_RST = '0;

  // ----------------------------------------------------------------
  // code table, sorted by code: code, warning class, servo kept on
  // ----------------------------------------------------------------
  localparam sac_entry_t SAC_TABLE [SAC_N] = '{
    '{8'h01, 1'b0, 1'b0}, // R2
    '{8'h02, 1'b0, 1'b0}, // R3
    '{8'h03, 1'b0, 1'b0}, // R1
    '{8'h04, 1'b0, 1'b0}, // R1
    '{8'h05, 1'b0, 1'b0}, // R1
    '{8'h06, 1'b0, 1'b0}, // R1
    '{8'h07, 1'b0, 1'b0}, // R4
    '{8'h08, 1'b0, 1'b0}, // R5
    '{8'h09, 1'b0, 1'b0}, // R6
    '{8'h0A, 1'b0, 1'b0}, // R1
    '{8'h0B, 1'b0, 1'b0}, // R1
    '{8'h0C, 1'b0, 1'b0}, // R8
    '{8'h0D, 1'b0, 1'b0}, // R1
    '{8'h0E, 1'b0, 1'b0}, // R1
    '{8'h0F, 1'b0, 1'b0}, // R1
    '{8'h10, 1'b0, 1'b0}, // R1
    '{8'h11, 1'b0, 1'b0}, // R7
    '{8'h12, 1'b1, 1'b1}, // R9
    '{8'h13, 1'b0, 1'b0}, // R10
    '{8'h14, 1'b0, 1'b0}, // R11
    '{8'h15, 1'b0, 1'b0}, // R1
    '{8'h16, 1'b0, 1'b0}, // R1
    '{8'h17, 1'b0, 1'b0}, // R1
    '{8'h18, 1'b0, 1'b0}, // R1
    '{8'h19, 1'b0, 1'b1}, // R12
    '{8'h1B, 1'b0, 1'b0}, // R13
    '{8'h1D, 1'b0, 1'b0}, // R1
    '{8'h32, 1'b1, 1'b0}, // R14
    '{8'h33, 1'b1, 1'b0}, // R15
    '{8'h34, 1'b1, 1'b1}, // R16
    '{8'h35, 1'b1, 1'b1}, // R17
    '{8'h36, 1'b0, 1'b0}, // R1
    '{8'h37, 1'b1, 1'b0}, // R18
    '{8'h38, 1'b1, 1'b0}, // R1
    '{8'h39, 1'b0, 1'b0}, // R19
    '{8'h3A, 1'b1, 1'b0}  // R20
  };

  function automatic logic [SAC_N-1:0] sac_warn_mask();
    logic [SAC_N-1:0] m;
    m = '0;
    for (int i = 0; i < SAC_N; i++) begin
      m[i] = SAC_TABLE[i].warn;
    end
    return m;
  endfunction

  function automatic logic [SAC_N-1:0] sac_off_mask();
    logic [SAC_N-1:0] m;
    m = '0;
    for (int i = 0; i < SAC_N; i++) begin
      m[i] = ~SAC_TABLE[i].keep_on;
    end
    return m;
  endfunction

endpackage

// ==== sac_enc_rel.sv ====
`timescale 1ns/1ps
module sac_enc_rel
  import sac_pkg::*;
#(
  parameter int RUN = sac_pkg::SAC_ENC_FAULT_RUN
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // encoder frame results
  input sac_pkg::sac_enc_frame_t frame,
  // reliability fault level
  output logic fault
);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  if (RUN < 1 || RUN > 3) begin : g_chk
    $error("sac_enc_rel: RUN must be 1 to 3");
  end

  localparam logic [1:0] RUN_MAX = 2'(RUN);

  sac_enc_state_t st_reg;
  sac_enc_state_t st_next;

  // ----------------------------------------------------------------
  // consecutive bad frame counter
  // ----------------------------------------------------------------
  // count saturates so a long bad run keeps the fault asserted
  always_comb begin
    st_next = st_reg;
    if (frame.valid && frame.bad) begin
      if (st_reg.run != RUN_MAX) begin
        st_next.run = st_reg.run + 2'h1; // R7
      end
    end else if (frame.valid) begin
      st_next.run = 2'h0; // R7
    end
    st_next.fault = (st_next.run == RUN_MAX); // R7
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= SAC_ENC_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign fault = st_reg.fault;

  // ----------------------------------------------------------------
  // checks on the counter
  // ----------------------------------------------------------------
  property p_enc_good_clears;
    @(posedge clk) disable iff (!nrst)
    (frame.valid && !frame.bad) |=> (st_reg.run == 2'h0) && !fault;
  endproperty
  a_enc_good_clears: assert property (p_enc_good_clears) // R7
    else $error("good encoder frame did not clear the run");

endmodule // sac_enc_rel

// ==== sac_classifier.sv ====
`timescale 1ns/1ps
// Summary of operation
// (R1) each condition maps to a code, an indication output and servo state
// (R2) overvoltage gives code 1, fault indication, servo off
// (R3) instantaneous overcurrent gives code 2, fault indication, servo off
// (R4) pulse command frequency above limit gives code 7, fault, servo off
// (R5) position error magnitude above threshold gives code 8, servo off
// (R6) encoder communication fault gives code 9, fault, servo off
// (R7) three consecutive encoder data faults give code 17; good frame resets
// (R8) parameter memory access fault gives code 12, fault, servo off
// (R9) motor overheat gives code 18 as warning, servo stays on
// (R10) serial link checksum fault gives code 19, fault, servo off
// (R11) serial link timeout gives code 20, fault, servo off
// (R12) encoder overheat gives code 25 as fault, servo stays on
// (R13) braking resistor overload gives code 27, fault, servo off
// (R14) main circuit undervoltage gives code 50 as warning, servo off
// (R15) emergency stop gives code 51 as warning, servo off
// (R16) counter-clockwise limit gives code 52 as warning, servo on
// (R17) clockwise limit gives code 53 as warning, servo on
// (R18) main power phase loss gives code 55 as warning, servo off
// (R19) cooling fan fault gives code 57 as fault, servo off
// (R20) signal processor fault gives code 58 as warning, servo off
// (R21) fault codes latch until clear with condition gone; warnings follow
// (R22) lowest active fault code wins, else lowest warning; any off wins
module sac_classifier
  import sac_pkg::*;
#(
  parameter int FREQ_W = sac_pkg::SAC_FREQ_W,
  parameter int PERR_W = sac_pkg::SAC_PERR_W,
  parameter int ENC_RUN = sac_pkg::SAC_ENC_FAULT_RUN
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // raw detector flags, one per table entry
  input wire logic [sac_pkg::SAC_N-1:0] cond_flags,
  // pulse command frequency check
  input wire logic [FREQ_W-1:0] pulse_freq,
  input wire logic [FREQ_W-1:0] pulse_freq_limit,
  // position error check, error is two's complement
  input wire logic [PERR_W-1:0] pos_err,
  input wire logic [PERR_W-1:0] pos_err_limit,
  // encoder frame results
  input sac_pkg::sac_enc_frame_t enc_frame,
  // fault clear request
  input wire logic clear_req,
  // indications
  output logic [sac_pkg::SAC_CODE_W-1:0] alarm_code,
  output logic fault_indication_output,
  output logic warning_indication_output,
  output logic servo_off
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (FREQ_W < 1 || FREQ_W > 32) begin : g_chk_freq
    $error("sac_classifier: FREQ_W out of range");
  end
  if (PERR_W < 2 || PERR_W > 32) begin : g_chk_perr
    $error("sac_classifier: PERR_W out of range");
  end

  typedef struct packed {
    logic found;
    logic [SAC_IDX_W-1:0] idx;
  } sac_pick_t;

  localparam logic [SAC_N-1:0] WARN_MASK = sac_warn_mask();
  localparam logic [SAC_N-1:0] ALARM_MASK = ~WARN_MASK;
  localparam logic [SAC_N-1:0] OFF_MASK = sac_off_mask();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // lowest set bit; the table is sorted, so lowest index is lowest code
  function automatic sac_pick_t first_set(input logic [SAC_N-1:0] v);
    sac_pick_t p;
    p = '0;
    for (int i = SAC_N - 1; i >= 0; i--) begin
      if (v[i]) begin
        p.found = 1'b1;
        p.idx = SAC_IDX_W'(i);
      end
    end
    return p;
  endfunction

  // most negative value saturates instead of wrapping back negative
  function automatic logic [PERR_W-1:0] mag(input logic [PERR_W-1:0] v);
    logic [PERR_W-1:0] r;
    r = v;
    if (v[PERR_W-1]) begin
      r = PERR_W'(~v + 1'b1);
      if (r[PERR_W-1]) begin
        r = {1'b0, {(PERR_W-1){1'b1}}};
      end
    end
    return r;
  endfunction

  sac_state_t st_reg;
  sac_state_t st_next;
  logic enc_rel_fault;
  logic [SAC_N-1:0] cond;
  logic [SAC_N-1:0] act_alarm;
  logic [SAC_N-1:0] act_warn;
  sac_pick_t pick_alarm;
  sac_pick_t pick_warn;

  // ----------------------------------------------------------------
  // encoder reliability counter
  // ----------------------------------------------------------------
  sac_enc_rel #(
    .RUN(ENC_RUN)
  ) u_enc_rel (
    .clk(clk),
    .nrst(nrst),
    .frame(enc_frame),
    .fault(enc_rel_fault)
  );

  // ----------------------------------------------------------------
  // condition vector
  // ----------------------------------------------------------------
  // derived entries ignore their raw flag bits
  always_comb begin
    cond = cond_flags;
    cond[SAC_IDX_PULSE_FREQ] = (pulse_freq > pulse_freq_limit); // R4
    cond[SAC_IDX_POS_ERR] = (mag(pos_err) > pos_err_limit); // R5
    cond[SAC_IDX_ENC_REL] = enc_rel_fault; // R7
  end

  // ----------------------------------------------------------------
  // latching, priority and indication
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // a condition still present keeps its bit even under clear
    st_next.latch = (cond & ALARM_MASK) |
                    (st_reg.latch & ~({SAC_N{clear_req}} & ~cond)); // R21
    act_alarm = st_next.latch & ALARM_MASK;
    act_warn = cond & WARN_MASK; // R21
    pick_alarm = first_set(act_alarm);
    pick_warn = first_set(act_warn);
    if (pick_alarm.found) begin
      st_next.ind.code = SAC_TABLE[pick_alarm.idx].code; // R22
    end else if (pick_warn.found) begin
      st_next.ind.code = SAC_TABLE[pick_warn.idx].code; // R22
    end else begin
      st_next.ind.code = SAC_CODE_NONE;
    end
    st_next.ind.fault = |act_alarm; // R1
    st_next.ind.warn = |act_warn; // R1
    st_next.ind.servo_off = |((act_alarm | act_warn) & OFF_MASK); // R22
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= SAC_STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign alarm_code = st_reg.ind.code;
  assign fault_indication_output = st_reg.ind.fault;
  assign warning_indication_output = st_reg.ind.warn;
  assign servo_off = st_reg.ind.servo_off;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_code_has_output;
    (alarm_code != SAC_CODE_NONE) |->
      (fault_indication_output || warning_indication_output);
  endproperty
  a_code_has_output: assert property (p_code_has_output) // R1
    else $error("code shown with no indication output");

  property p_overvolt;
    cond_flags[SAC_IDX_OVERVOLT] |=>
      (alarm_code == 8'h01) && fault_indication_output && servo_off;
  endproperty
  a_overvolt: assert property (p_overvolt) // R2
    else $error("overvoltage not reported as code 1");

  property p_overcur;
    cond_flags[SAC_IDX_OVERCUR] && !cond_flags[SAC_IDX_OVERVOLT] &&
      !st_reg.latch[SAC_IDX_OVERVOLT] |=>
      (alarm_code == 8'h02) && servo_off;
  endproperty
  a_overcur: assert property (p_overcur) // R3
    else $error("overcurrent not reported as code 2");

  property p_pulse_freq;
    (pulse_freq > pulse_freq_limit) |=>
      st_reg.latch[SAC_IDX_PULSE_FREQ] && fault_indication_output;
  endproperty
  a_pulse_freq: assert property (p_pulse_freq) // R4
    else $error("pulse frequency fault not latched");

  property p_pos_err;
    !pos_err[PERR_W-1] && (pos_err > pos_err_limit) |=>
      st_reg.latch[SAC_IDX_POS_ERR] && servo_off;
  endproperty
  a_pos_err: assert property (p_pos_err) // R5
    else $error("position error fault not latched");

  property p_enc_comm;
    cond_flags[SAC_IDX_ENC_COMM] |=>
      st_reg.latch[SAC_IDX_ENC_COMM] && servo_off;
  endproperty
  a_enc_comm: assert property (p_enc_comm) // R6
    else $error("encoder communication fault not latched");

  sequence s_bad_frame;
    enc_frame.valid && enc_frame.bad;
  endsequence

  property p_enc_rel;
    s_bad_frame [*3] |-> ##2 st_reg.latch[SAC_IDX_ENC_REL];
  endproperty
  a_enc_rel: assert property (p_enc_rel) // R7
    else $error("third bad encoder frame did not raise code 17");

  property p_motor_hot;
    (cond == (SAC_N'(1) << SAC_IDX_MOTOR_HOT)) && (st_reg.latch == '0)
      |=> (alarm_code == 8'h12) && warning_indication_output &&
      !fault_indication_output && !servo_off;
  endproperty
  a_motor_hot: assert property (p_motor_hot) // R9
    else $error("motor overheat not a warning with servo on");

  property p_enc_hot;
    (cond == (SAC_N'(1) << SAC_IDX_ENC_HOT)) && (st_reg.latch == '0)
      |=> (alarm_code == 8'h19) && fault_indication_output && !servo_off;
  endproperty
  a_enc_hot: assert property (p_enc_hot) // R12
    else $error("encoder overheat not a fault with servo on");

  property p_estop;
    (cond == (SAC_N'(1) << SAC_IDX_ESTOP)) && (st_reg.latch == '0)
      |=> (alarm_code == 8'h33) && warning_indication_output && servo_off;
  endproperty
  a_estop: assert property (p_estop) // R15
    else $error("emergency stop not a warning with servo off");

  property p_limit_sw;
    (cond == (SAC_N'(1) << SAC_IDX_CW)) && (st_reg.latch == '0)
      |=> (alarm_code == 8'h35) && !servo_off && !fault_indication_output;
  endproperty
  a_limit_sw: assert property (p_limit_sw) // R17
    else $error("clockwise limit not a warning with servo on");

  property p_undervolt;
    (cond == (SAC_N'(1) << SAC_IDX_UNDERVOLT)) && (st_reg.latch == '0)
      |=> (alarm_code == 8'h32) && warning_indication_output && servo_off;
  endproperty
  a_undervolt: assert property (p_undervolt) // R14
    else $error("undervoltage not a warning with servo off");

  property p_ccw;
    (cond == (SAC_N'(1) << SAC_IDX_CCW)) && (st_reg.latch == '0)
      |=> (alarm_code == 8'h34) && warning_indication_output && !servo_off;
  endproperty
  a_ccw: assert property (p_ccw) // R16
    else $error("counter-clockwise limit not a warning with servo on");

  property p_fan;
    (cond == (SAC_N'(1) << SAC_IDX_FAN)) && (st_reg.latch == '0)
      |=> (alarm_code == 8'h39) && fault_indication_output && servo_off;
  endproperty
  a_fan: assert property (p_fan) // R19
    else $error("fan fault not a fault with servo off");

  property p_dsp;
    (cond == (SAC_N'(1) << SAC_IDX_DSP)) && (st_reg.latch == '0)
      |=> (alarm_code == 8'h3A) && warning_indication_output && servo_off;
  endproperty
  a_dsp: assert property (p_dsp) // R20
    else $error("processor fault not a warning with servo off");

  property p_latch_holds;
    !clear_req |=> ((st_reg.latch & $past(st_reg.latch)) ==
      $past(st_reg.latch));
  endproperty
  a_latch_holds: assert property (p_latch_holds) // R21
    else $error("fault latch dropped without clear");

  property p_clear_works;
    clear_req && (cond == '0) |=> (st_reg.latch == '0) &&
      !fault_indication_output && (alarm_code == SAC_CODE_NONE);
  endproperty
  a_clear_works: assert property (p_clear_works) // R21
    else $error("clear with no condition left a fault");

  property p_warn_follows;
    (cond & WARN_MASK) == '0 |=> !warning_indication_output;
  endproperty
  a_warn_follows: assert property (p_warn_follows) // R21
    else $error("warning held after its condition went");

  property p_priority;
    cond_flags[SAC_IDX_OVERVOLT] && cond_flags[SAC_IDX_UNDERVOLT]
      |=> (alarm_code == 8'h01) && warning_indication_output;
  endproperty
  a_priority: assert property (p_priority) // R22
    else $error("fault code did not win over warning code");

  property p_any_off;
    (cond == ((SAC_N'(1) << SAC_IDX_CCW) | (SAC_N'(1) << SAC_IDX_PHASE)))
      && (st_reg.latch == '0) |=> servo_off && (alarm_code == 8'h34);
  endproperty
  a_any_off: assert property (p_any_off) // R22
    else $error("servo off demand lost under a lower code");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  c_enc_rel: cover property (s_bad_frame [*3] ##2
    st_reg.latch[SAC_IDX_ENC_REL]);
  c_clear: cover property (st_reg.latch != '0 ##1
    clear_req && (cond == '0) ##1 st_reg.latch == '0);
  c_warn_only: cover property (warning_indication_output &&
    !fault_indication_output && servo_off);
  c_both: cover property (warning_indication_output &&
    fault_indication_output);

endmodule // sac_classifier

// ==== sac_sensor_model.sv ====
`timescale 1ns/1ps
module sac_sensor_model
  import sac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // requests from the bench
  input wire logic [sac_pkg::SAC_N-1:0] flags_req,
  input wire logic [sac_pkg::SAC_FREQ_W-1:0] freq_req,
  input wire logic [sac_pkg::SAC_FREQ_W-1:0] freq_lim_req,
  input wire logic [sac_pkg::SAC_PERR_W-1:0] perr_req,
  input wire logic [sac_pkg::SAC_PERR_W-1:0] perr_lim_req,
  input wire logic frame_go,
  input wire logic frame_bad,
  // detector side of the classifier
  output logic [sac_pkg::SAC_N-1:0] cond_flags,
  output logic [sac_pkg::SAC_FREQ_W-1:0] pulse_freq,
  output logic [sac_pkg::SAC_FREQ_W-1:0] pulse_freq_limit,
  output logic [sac_pkg::SAC_PERR_W-1:0] pos_err,
  output logic [sac_pkg::SAC_PERR_W-1:0] pos_err_limit,
  output sac_pkg::sac_enc_frame_t enc_frame
);
  import sac_pkg::*;
  // ----------------------------------------------------------------
  // junk pattern
  // ----------------------------------------------------------------
  // changes every cycle out of reset, held low in reset, so a stale value never looks like real data
  logic junk_reg;
  always_ff @(posedge clk) begin
    junk_reg <= nrst ? ~junk_reg : 1'b0;
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // derived entries carry junk on their raw bits, as a real board may
  always_comb begin
    cond_flags = flags_req;
    cond_flags[SAC_IDX_PULSE_FREQ] = junk_reg;
    cond_flags[SAC_IDX_POS_ERR] = ~junk_reg;
    cond_flags[SAC_IDX_ENC_REL] = junk_reg;
    enc_frame.valid = frame_go;
    enc_frame.bad = frame_go ? frame_bad : junk_reg;
  end
  assign pulse_freq = freq_req;
  assign pulse_freq_limit = freq_lim_req;
  assign pos_err = perr_req;
  assign pos_err_limit = perr_lim_req;
endmodule // sac_sensor_model

// ==== sac_classifier_tb.sv ====
`timescale 1ns/1ps
module sac_classifier_tb;
  import sac_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [SAC_N-1:0] flags_req = '0;
  logic [SAC_FREQ_W-1:0] freq_req = '0;
  logic [SAC_FREQ_W-1:0] freq_lim_req = 16'h1000;
  logic [SAC_PERR_W-1:0] perr_req = '0;
  logic [SAC_PERR_W-1:0] perr_lim_req = 24'h00_0100;
  logic frame_go = 1'b0;
  logic frame_bad = 1'b0;
  logic clear_req = 1'b0;
  logic [SAC_N-1:0] cond_flags;
  logic [SAC_FREQ_W-1:0] pulse_freq;
  logic [SAC_FREQ_W-1:0] pulse_freq_limit;
  logic [SAC_PERR_W-1:0] pos_err;
  logic [SAC_PERR_W-1:0] pos_err_limit;
  sac_enc_frame_t enc_frame;
  logic [SAC_CODE_W-1:0] alarm_code;
  logic fault_indication_output;
  logic warning_indication_output;
  logic servo_off;
  int n_fail = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  sac_sensor_model u_sac_sensor_model (
    .clk(clk), .nrst(nrst), .flags_req(flags_req), .freq_req(freq_req),
    .freq_lim_req(freq_lim_req), .perr_req(perr_req),
    .perr_lim_req(perr_lim_req), .frame_go(frame_go),
    .frame_bad(frame_bad), .cond_flags(cond_flags),
    .pulse_freq(pulse_freq), .pulse_freq_limit(pulse_freq_limit),
    .pos_err(pos_err), .pos_err_limit(pos_err_limit),
    .enc_frame(enc_frame)
  );
  sac_classifier u_sac_classifier (
    .clk(clk), .nrst(nrst), .cond_flags(cond_flags),
    .pulse_freq(pulse_freq), .pulse_freq_limit(pulse_freq_limit),
    .pos_err(pos_err), .pos_err_limit(pos_err_limit),
    .enc_frame(enc_frame), .clear_req(clear_req),
    .alarm_code(alarm_code),
    .fault_indication_output(fault_indication_output),
    .warning_indication_output(warning_indication_output),
    .servo_off(servo_off)
  );
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_out(string nm, logic [7:0] c, logic f, logic w,
                         logic o);
    checks_done++;
    if ({alarm_code, fault_indication_output, warning_indication_output,
         servo_off} !== {c, f, w, o}) begin
      n_fail++;
      $display("[FAIL] %s exp %h %b%b%b seen %h %b%b%b", nm, c, f, w, o,
               alarm_code, fault_indication_output,
               warning_indication_output, servo_off);
    end
  endtask
  // one edge to launch, one edge for the registered answer
  task automatic apply(logic [SAC_N-1:0] fl, logic clr);
    @(posedge clk);
    flags_req <= fl;
    clear_req <= clr;
    repeat (2) @(negedge clk);
  endtask
  task automatic set_meas(logic [15:0] f, logic [23:0] p);
    @(posedge clk);
    freq_req <= f;
    perr_req <= p;
    repeat (2) @(negedge clk);
  endtask
  task automatic send_frame(logic bad);
    @(posedge clk);
    frame_go <= 1'b1;
    frame_bad <= bad;
    @(posedge clk);
    frame_go <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // three bad frames on three edges in a row
  task automatic send_burst();
    @(posedge clk);
    frame_go <= 1'b1;
    frame_bad <= 1'b1;
    repeat (3) @(posedge clk);
    frame_go <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  function automatic logic [7:0] exp_code(int i);
    if (i < 25) return 8'(i + 1);
    if (i == 25) return 8'h1b;
    if (i == 26) return 8'h1d;
    return 8'(i + 23);
  endfunction
  function automatic logic is_warn(logic [7:0] c);
    return c inside {8'h12, 8'h32, 8'h33, 8'h34, 8'h35, 8'h37, 8'h38,
                     8'h3a};
  endfunction
  function automatic logic keeps_on(logic [7:0] c);
    return c inside {8'h12, 8'h19, 8'h34, 8'h35};
  endfunction
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // clear is held high while raising: set must win over clear
  task automatic t_table();
    logic [7:0] c;
    logic w;
    logic k;
    for (int i = 0; i < SAC_N; i++) begin
      if (i == 6 || i == 7 || i == 16) continue;
      c = exp_code(i);
      w = is_warn(c);
      k = keeps_on(c);
      apply(SAC_N'(1) << i, 1'b1);
      chk_out("raised", c, ~w, w, ~k);
      apply('0, 1'b0);
      chk_out("held", w ? 8'h00 : c, ~w, 1'b0, ~w & ~k);
      apply('0, 1'b1);
      chk_out("cleared", 8'h00, 1'b0, 1'b0, 1'b0);
    end
  endtask
  task automatic t_limits();
    logic [15:0] fv [7] = '{16'h1000, 16'h1001, 16'h0000, 16'h0000,
                            16'h0000, 16'h0000, 16'h0000};
    logic [23:0] pv [7] = '{24'h00_0000, 24'h00_0000, 24'hff_ff00,
                            24'hff_feff, 24'h00_0101, 24'h80_0000,
                            24'h00_0100};
    logic [7:0] cv [7] = '{8'h00, 8'h07, 8'h00, 8'h08, 8'h08, 8'h08,
                           8'h00};
    for (int i = 0; i < 7; i++) begin
      set_meas(fv[i], pv[i]);
      chk_out("limit", cv[i], cv[i] != 0, 1'b0, cv[i] != 0);
      set_meas(16'h0000, 24'h00_0000);
      apply('0, 1'b1);
      apply('0, 1'b0);
    end
  endtask
  task automatic t_enc();
    send_frame(1'b1);
    send_frame(1'b1);
    chk_out("enc two bad", 8'h00, 1'b0, 1'b0, 1'b0);
    send_frame(1'b0);
    send_frame(1'b1);
    send_frame(1'b1);
    chk_out("enc run reset", 8'h00, 1'b0, 1'b0, 1'b0);
    send_frame(1'b1);
    chk_out("enc third bad", 8'h11, 1'b1, 1'b0, 1'b1);
    send_frame(1'b0);
    chk_out("enc latched", 8'h11, 1'b1, 1'b0, 1'b1);
    apply('0, 1'b1);
    chk_out("enc cleared", 8'h00, 1'b0, 1'b0, 1'b0);
    send_burst();
    chk_out("enc back to back", 8'h11, 1'b1, 1'b0, 1'b1);
    send_frame(1'b0);
    apply('0, 1'b1);
    chk_out("enc burst cleared", 8'h00, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_priority();
    logic [SAC_N-1:0] m;
    m = '0;
    m[35] = 1'b1;
    m[24] = 1'b1;
    m[17] = 1'b1;
    apply(m, 1'b0);
    chk_out("mixed", 8'h19, 1'b1, 1'b1, 1'b1);
    m = '0;
    m[29] = 1'b1;
    m[17] = 1'b1;
    apply(m, 1'b1);
    chk_out("warnings", 8'h12, 1'b0, 1'b1, 1'b0);
    m = '0;
    m[0] = 1'b1;
    m[27] = 1'b1;
    apply(m, 1'b0);
    chk_out("fault over warning", 8'h01, 1'b1, 1'b1, 1'b1);
    apply('0, 1'b1);
    chk_out("fault cleared", 8'h00, 1'b0, 1'b0, 1'b0);
    m = '0;
    m[29] = 1'b1;
    m[32] = 1'b1;
    apply(m, 1'b0);
    chk_out("off from higher code", 8'h34, 1'b0, 1'b1, 1'b1);
    apply('0, 1'b0);
    chk_out("idle", 8'h00, 1'b0, 1'b0, 1'b0);
  endtask
  // latched state must not survive a reset in mid-run
  task automatic t_reset();
    apply(SAC_N'(1), 1'b0);
    apply('0, 1'b0);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(negedge clk);
    chk_out("in reset", 8'h00, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(negedge clk);
    chk_out("after reset", 8'h00, 1'b0, 1'b0, 1'b0);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_table();
    t_limits();
    t_enc();
    t_priority();
    t_reset();
    report_and_stop();
  end
  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end
endmodule // sac_classifier_tb
